// File: common/core_regs_pkg.sv
package core_regs_pkg;

   // register indices, byte address is four times the index
   localparam logic [2:0]  IDX_WINDOW   = 3'h0;
   localparam logic [2:0]  IDX_BANK     = 3'h1;
   localparam logic [2:0]  IDX_PCL      = 3'h2;
   localparam logic [2:0]  IDX_STATUS   = 3'h3;
   localparam logic [2:0]  IDX_RAMPTR   = 3'h4;
   localparam int unsigned ADDR_W       = 12;
   localparam int unsigned IDX_LSB      = 2;
   localparam int unsigned IDX_W        = 3;

   // bank select layout
   localparam logic [7:0]  BANK_WR_MASK = 8'h77;
   localparam logic [7:0]  BANK_RESET   = 8'h00;
   localparam int unsigned SBS_LSB      = 4;
   localparam int unsigned GBS_LSB      = 0;
   localparam int unsigned SEL_W        = 3;

   // ram pointer, low bits address the window
   localparam logic [7:0]  RAMPTR_RESET = 8'h00;
   localparam int unsigned IND_W        = 6;

   // status bit positions and values after reset
   localparam int unsigned ST_INT       = 5;
   localparam int unsigned ST_T         = 4;
   localparam int unsigned ST_P         = 3;
   localparam int unsigned ST_Z         = 2;
   localparam int unsigned ST_DC        = 1;
   localparam int unsigned ST_C         = 0;
   localparam logic        INT_RESET    = 1'h0;
   localparam logic        T_RESET      = 1'h1;
   localparam logic        P_RESET      = 1'h1;
   localparam logic        FLAG_RESET   = 1'h0;

   // program counter and return stack
   localparam int unsigned PC_W         = 12;
   localparam int unsigned PAGE_W       = 10;
   localparam int unsigned PCL_W        = 8;
   localparam logic [11:0] PC_RESET     = 12'h000;
   localparam int unsigned STACK_DEPTH  = 8;
   localparam int unsigned SP_W         = 3;
   localparam logic [2:0]  SP_RESET     = 3'h0;
   typedef logic [SP_W-1:0] sp_t;

   // operations issued by the decoder
   typedef enum logic [4:0] {
      OP_NOP, OP_PAGE_BRANCH, OP_PAGE_CALL, OP_LONG_BRANCH,
      OP_LONG_SUBROUTINE, OP_RETURN, OP_RETURN_LITERAL, OP_IRQ_RETURN,
      OP_IRQ_ENTRY, OP_ADD_PC, OP_WRITE_PC, OP_IRQ_MASK, OP_IRQ_UNMASK,
      OP_HALT, OP_WATCHDOG_KICK, OP_TABLE_FETCH, OP_ADD, OP_SUB,
      OP_LOGIC, OP_RLC, OP_RRC
   } op_t;

   // instruction cycle phases
   typedef enum logic [3:0] {
      PH_LEAD   = 4'b0001,
      PH_TRAIL  = 4'b0010,
      PH_XLEAD  = 4'b0100,
      PH_XTRAIL = 4'b1000
   } phase_t;

   typedef struct packed {
      op_t         op;
      logic [11:0] target;
      logic [7:0]  a;
      logic [7:0]  b;
   } cmd_t;

endpackage

// File: core/core_bank_pc_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - window holds nothing, reaches pointed location
// - window address is low six pointer bits
// - bank select bits 7 and 3 read zero
// - bits 6..4 pick special register bank
// - bits 2..0 pick general register bank
// - twelve bit counter and stack entries
// - return stack eight entries deep
// - reset clears the program counter
// - page branch replaces low ten bits
// - page call loads ten bits, pushes next
// - long branch loads all twelve bits
// - long call loads twelve bits, pushes next
// - returns load counter from top, pop
// - add to counter is relative, carries up
// - move to counter replaces low eight bits
// - other counter writes keep bits 8 and 9
// - two clocks per cycle, some take two
// - status bits 7 and 6 read zero
// - interrupt enable cleared and set by ops
// - time-out set by halt, kick, power-up
// - power-down set by kick, cleared by halt
// - zero flag follows add, subtract, logic result
// - carry on add, no borrow on subtract
// - carry links ends of rotated byte
module core_bank_pc_status_regs (
   // clock and reset
   input  wire logic                 clock,
   input  wire logic                 resetn,
   // apb slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   // decoder commands
   input  wire logic                 cmd_valid,
   input  wire core_regs_pkg::cmd_t  cmd,
   output logic                      cmd_ready,
   // watchdog
   input  wire logic                 wdt_timeout,
   // window onto data memory
   output logic      [5:0]           indirect_pointer,
   output logic                      ind_write,
   output logic      [7:0]           ind_wdata,
   input  wire logic [7:0]           ind_rdata,
   // core state
   output logic      [11:0]          program_counter,
   output logic      [2:0]           special_bank_sel,
   output logic      [2:0]           general_bank_sel,
   output logic      [7:0]           alu_result,
   output logic                      irq_enable,
   output logic                      time_out,
   output logic                      power_down,
   output logic                      zero,
   output logic                      half_carry,
   output logic                      carry
);

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);

   logic [2:0]                 idx;
   logic                       mapped;
   logic                       apb_wr;
   logic                       take;
   logic                       is_push;
   logic                       is_pop;
   logic                       is_long;
   logic                       long_q;
   core_regs_pkg::phase_t      phase;
   core_regs_pkg::phase_t      next_phase;
   logic [11:0]                pc_seq;
   logic [11:0]                push_val;
   logic [11:0]                stack_top;
   logic [11:0]                stack [core_regs_pkg::STACK_DEPTH];
   core_regs_pkg::sp_t         sp;
   core_regs_pkg::sp_t         sp_top;
   logic [7:0]                 bank_select;
   logic [7:0]                 ram_pointer_reg;
   logic [8:0]                 sum9;
   logic [4:0]                 half5;
   logic [8:0]                 diff9;
   logic [4:0]                 hdiff5;
   logic [7:0]                 next_res;
   logic                       next_z;
   logic                       next_dc;
   logic                       next_c;

   // bus decode, zero wait states
   assign idx = paddr[core_regs_pkg::IDX_LSB +: core_regs_pkg::IDX_W];
   assign mapped = (paddr[core_regs_pkg::ADDR_W-1:5] == '0)
                && (paddr[1:0] == 2'h0)
                && (idx <= core_regs_pkg::IDX_RAMPTR);
   assign apb_wr = psel && penable && pwrite && mapped;
   assign pready = 1'b1;

   // read data captured in the setup cycle so prdata is a flop
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         pslverr <= !mapped;
         case (idx)
            core_regs_pkg::IDX_WINDOW: prdata <= {24'h00_0000, ind_rdata};
            core_regs_pkg::IDX_BANK:   prdata <= {24'h00_0000, bank_select};
            core_regs_pkg::IDX_PCL:
               prdata <= {24'h00_0000, program_counter[7:0]};
            core_regs_pkg::IDX_STATUS:
               prdata <= {24'h00_0000, 2'h0, irq_enable, time_out,
                          power_down, zero, half_carry, carry};
            core_regs_pkg::IDX_RAMPTR:
               prdata <= {24'h00_0000, ram_pointer_reg};
            default:   prdata <= 32'h0000_0000;
         endcase
      end
   end

   // window writes go out to data memory, nothing stored here
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ind_write <= 1'b0;
         ind_wdata <= 8'h00;
      end else begin
         ind_write <= apb_wr && (idx == core_regs_pkg::IDX_WINDOW);
         ind_wdata <= pwdata[7:0];
      end
   end

   assign indirect_pointer = ram_pointer_reg[core_regs_pkg::IND_W-1:0];

   AST_WINDOW_WRITE: assert property (
      apb_wr && (idx == core_regs_pkg::IDX_WINDOW)
      |=> ind_write && (ind_wdata == $past(pwdata[7:0]))
          && (indirect_pointer == $past(ram_pointer_reg[5:0])))
      else $error("window write not forwarded to pointed location");

   AST_WINDOW_READ: assert property (
      psel && penable && !pwrite && mapped
      && (idx == core_regs_pkg::IDX_WINDOW)
      |-> prdata[7:0] == $past(ind_rdata))
      else $error("window read did not return pointed data");

   // pointer register
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn)
         ram_pointer_reg <= core_regs_pkg::RAMPTR_RESET;
      else if (apb_wr && (idx == core_regs_pkg::IDX_RAMPTR))
         ram_pointer_reg <= pwdata[7:0];
   end

   // bank select, unused bits never store a one
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn)
         bank_select <= core_regs_pkg::BANK_RESET;
      else if (apb_wr && (idx == core_regs_pkg::IDX_BANK))
         bank_select <= pwdata[7:0] & core_regs_pkg::BANK_WR_MASK;
   end

   assign special_bank_sel =
      bank_select[core_regs_pkg::SBS_LSB +: core_regs_pkg::SEL_W];
   assign general_bank_sel =
      bank_select[core_regs_pkg::GBS_LSB +: core_regs_pkg::SEL_W];

   AST_BANK_MASK: assert property (
      apb_wr && (idx == core_regs_pkg::IDX_BANK)
      |=> (bank_select[7] == 1'b0) && (bank_select[3] == 1'b0)
          && (special_bank_sel == $past(pwdata[6:4]))
          && (general_bank_sel == $past(pwdata[2:0])))
      else $error("bank select write wrong");

   // command decode
   assign cmd_ready = (phase == core_regs_pkg::PH_LEAD);
   assign take = cmd_valid && cmd_ready;
   assign pc_seq = program_counter + 12'h001;
   assign sp_top = sp - 3'h1;
   assign stack_top = stack[sp_top];

   always_comb begin
      is_push = 1'b0;
      is_pop = 1'b0;
      is_long = 1'b1;
      case (cmd.op)
         core_regs_pkg::OP_PAGE_CALL,
         core_regs_pkg::OP_LONG_SUBROUTINE,
         core_regs_pkg::OP_IRQ_ENTRY:      is_push = 1'b1;
         core_regs_pkg::OP_RETURN,
         core_regs_pkg::OP_RETURN_LITERAL,
         core_regs_pkg::OP_IRQ_RETURN:     is_pop = 1'b1;
         core_regs_pkg::OP_PAGE_BRANCH,
         core_regs_pkg::OP_LONG_BRANCH,
         core_regs_pkg::OP_ADD_PC,
         core_regs_pkg::OP_WRITE_PC,
         core_regs_pkg::OP_TABLE_FETCH:    is_long = 1'b1;
         default:                          is_long = 1'b0;
      endcase
      if (is_push || is_pop)
         is_long = 1'b1;
   end

   // interrupt entry returns to the instruction it displaced
   assign push_val = (cmd.op == core_regs_pkg::OP_IRQ_ENTRY)
                   ? program_counter : pc_seq;

   // phase machine, two clocks per instruction cycle
   always_comb begin
      next_phase = phase;
      case (phase)
         core_regs_pkg::PH_LEAD:
            if (take)
               next_phase = core_regs_pkg::PH_TRAIL;
         core_regs_pkg::PH_TRAIL:
            next_phase = long_q ? core_regs_pkg::PH_XLEAD
                                : core_regs_pkg::PH_LEAD;
         core_regs_pkg::PH_XLEAD:
            next_phase = core_regs_pkg::PH_XTRAIL;
         core_regs_pkg::PH_XTRAIL:
            next_phase = core_regs_pkg::PH_LEAD;
         default:
            next_phase = core_regs_pkg::PH_LEAD;
      endcase
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         phase  <= core_regs_pkg::PH_LEAD;
         long_q <= 1'b0;
      end else begin
         phase <= next_phase;
         if (take)
            long_q <= is_long;
      end
   end

   AST_SHORT_CYCLE: assert property (
      take && !is_long |=> !cmd_ready ##1 cmd_ready)
      else $error("single cycle instruction not two clocks");

   AST_LONG_CYCLE: assert property (
      take && is_long |=> !cmd_ready [*3] ##1 cmd_ready)
      else $error("two cycle instruction not four clocks");

   // program counter; a bus write in the same edge as a command is lost
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         program_counter <= core_regs_pkg::PC_RESET;
      end else if (take) begin
         case (cmd.op)
            core_regs_pkg::OP_PAGE_BRANCH,
            core_regs_pkg::OP_PAGE_CALL:
               program_counter <= {program_counter[11:10],
                                   cmd.target[core_regs_pkg::PAGE_W-1:0]};
            core_regs_pkg::OP_LONG_BRANCH,
            core_regs_pkg::OP_LONG_SUBROUTINE,
            core_regs_pkg::OP_IRQ_ENTRY:
               program_counter <= cmd.target;
            core_regs_pkg::OP_RETURN,
            core_regs_pkg::OP_RETURN_LITERAL,
            core_regs_pkg::OP_IRQ_RETURN:
               program_counter <= stack_top;
            core_regs_pkg::OP_ADD_PC:
               program_counter <= pc_seq + {4'h0, cmd.a};
            core_regs_pkg::OP_WRITE_PC:
               program_counter <= {program_counter[11:8], cmd.a};
            default:
               program_counter <= pc_seq;
         endcase
      end else if (apb_wr && (idx == core_regs_pkg::IDX_PCL)) begin
         program_counter <= {program_counter[11:8], pwdata[7:0]};
      end
   end

   // return stack, one flop group per entry; overflow wraps silently
   for (genvar i = 0; i < core_regs_pkg::STACK_DEPTH; i++) begin : g_stack
      always_ff @(posedge clock or negedge resetn) begin
         if (!resetn)
            stack[i] <= core_regs_pkg::PC_RESET;
         else if (take && is_push && (sp == core_regs_pkg::sp_t'(i)))
            stack[i] <= push_val;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn)
         sp <= core_regs_pkg::SP_RESET;
      else if (take && is_push)
         sp <= sp + 3'h1;
      else if (take && is_pop)
         sp <= sp - 3'h1;
   end

   AST_PC_RESET: assert property (
      $rose(resetn) |-> program_counter == 12'h000)
      else $error("counter not clear after reset");

   AST_PAGE_BRANCH: assert property (
      take && (cmd.op == core_regs_pkg::OP_PAGE_BRANCH)
      |=> program_counter == {$past(program_counter[11:10]),
                              $past(cmd.target[9:0])})
      else $error("page branch loaded wrong bits");

   AST_PAGE_CALL: assert property (
      take && (cmd.op == core_regs_pkg::OP_PAGE_CALL)
      |=> (stack_top == $past(pc_seq))
          && (program_counter[9:0] == $past(cmd.target[9:0])))
      else $error("page call wrong push or target");

   AST_LONG_BRANCH: assert property (
      take && (cmd.op == core_regs_pkg::OP_LONG_BRANCH)
      |=> program_counter == $past(cmd.target))
      else $error("long branch target wrong");

   AST_CALL_RETURN: assert property (
      take && (cmd.op == core_regs_pkg::OP_LONG_SUBROUTINE)
      ##4 take && (cmd.op == core_regs_pkg::OP_RETURN)
      |=> program_counter == $past(pc_seq, 5))
      else $error("return did not reach call successor");

   AST_RETURN_POP: assert property (
      take && is_pop
      |=> (program_counter == $past(stack_top)) && (sp == $past(sp_top)))
      else $error("return did not pop top entry");

   AST_ADD_PC: assert property (
      take && (cmd.op == core_regs_pkg::OP_ADD_PC)
      |=> program_counter == $past(pc_seq) + {4'h0, $past(cmd.a)})
      else $error("relative add wrong");

   AST_WRITE_PC: assert property (
      (take && (cmd.op == core_regs_pkg::OP_WRITE_PC))
      || (!take && apb_wr && (idx == core_regs_pkg::IDX_PCL))
      |=> program_counter[11:8] == $past(program_counter[11:8]))
      else $error("counter write changed upper bits");

   // alu flag sources
   assign sum9   = {1'b0, cmd.a} + {1'b0, cmd.b};
   assign half5  = {1'b0, cmd.a[3:0]} + {1'b0, cmd.b[3:0]};
   assign diff9  = {1'b0, cmd.b} - {1'b0, cmd.a};
   assign hdiff5 = {1'b0, cmd.b[3:0]} - {1'b0, cmd.a[3:0]};

   // subtract is b minus a; a set carry means no borrow
   always_comb begin
      next_res = cmd.a;
      next_z   = zero;
      next_dc  = half_carry;
      next_c   = carry;
      case (cmd.op)
         core_regs_pkg::OP_ADD: begin
            next_res = sum9[7:0];
            next_c   = sum9[8];
            next_dc  = half5[4];
         end
         core_regs_pkg::OP_SUB: begin
            next_res = diff9[7:0];
            next_c   = !diff9[8];
            next_dc  = !hdiff5[4];
         end
         core_regs_pkg::OP_RLC: begin
            next_res = {cmd.a[6:0], carry};
            next_c   = cmd.a[7];
         end
         core_regs_pkg::OP_RRC: begin
            next_res = {carry, cmd.a[7:1]};
            next_c   = cmd.a[0];
         end
         default: next_res = cmd.a;
      endcase
      if ((cmd.op == core_regs_pkg::OP_ADD)
          || (cmd.op == core_regs_pkg::OP_SUB)
          || (cmd.op == core_regs_pkg::OP_LOGIC))
         next_z = (next_res == 8'h00);
   end

   // arithmetic flags; an alu op in the same edge beats a bus write
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         zero       <= core_regs_pkg::FLAG_RESET;
         half_carry <= core_regs_pkg::FLAG_RESET;
         carry      <= core_regs_pkg::FLAG_RESET;
         alu_result <= 8'h00;
      end else begin
         if (apb_wr && (idx == core_regs_pkg::IDX_STATUS)) begin
            zero       <= pwdata[core_regs_pkg::ST_Z];
            half_carry <= pwdata[core_regs_pkg::ST_DC];
            carry      <= pwdata[core_regs_pkg::ST_C];
         end
         if (take && (cmd.op >= core_regs_pkg::OP_ADD)) begin
            zero       <= next_z;
            half_carry <= next_dc;
            carry      <= next_c;
            alu_result <= next_res;
         end
      end
   end

   // interrupt enable; the command wins over a bus write
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         irq_enable <= core_regs_pkg::INT_RESET;
      end else begin
         if (apb_wr && (idx == core_regs_pkg::IDX_STATUS))
            irq_enable <= pwdata[core_regs_pkg::ST_INT];
         if (take && ((cmd.op == core_regs_pkg::OP_IRQ_MASK)
                      || (cmd.op == core_regs_pkg::OP_IRQ_ENTRY)))
            irq_enable <= 1'b0;
         if (take && ((cmd.op == core_regs_pkg::OP_IRQ_UNMASK)
                      || (cmd.op == core_regs_pkg::OP_IRQ_RETURN)))
            irq_enable <= 1'b1;
      end
   end

   // time-out and power-down; reset stands for power-up, set beats clear
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         time_out   <= core_regs_pkg::T_RESET;
         power_down <= core_regs_pkg::P_RESET;
      end else begin
         if (wdt_timeout)
            time_out <= 1'b0;
         if (take && ((cmd.op == core_regs_pkg::OP_HALT)
                      || (cmd.op == core_regs_pkg::OP_WATCHDOG_KICK)))
            time_out <= 1'b1;
         if (take && (cmd.op == core_regs_pkg::OP_HALT))
            power_down <= 1'b0;
         if (take && (cmd.op == core_regs_pkg::OP_WATCHDOG_KICK))
            power_down <= 1'b1;
      end
   end

   AST_STATUS_READ: assert property (
      psel && penable && !pwrite && mapped
      && (idx == core_regs_pkg::IDX_STATUS)
      |-> (prdata[7:6] == 2'h0) && (prdata[5] == $past(irq_enable))
          && (prdata[0] == $past(carry)))
      else $error("status read wrong");

   AST_IRQ_ENABLE: assert property (
      take && (cmd.op == core_regs_pkg::OP_IRQ_ENTRY)
      |=> !irq_enable ##1 !irq_enable)
      else $error("interrupt entry left enable set");

   AST_TIME_OUT: assert property (
      wdt_timeout && !(take && (cmd.op == core_regs_pkg::OP_HALT)
                       || take && (cmd.op == core_regs_pkg::OP_WATCHDOG_KICK))
      |=> !time_out)
      else $error("time-out not cleared by watchdog");

   AST_HALT: assert property (
      take && (cmd.op == core_regs_pkg::OP_HALT)
      |=> time_out && !power_down)
      else $error("halt flags wrong");

   AST_ADD_FLAGS: assert property (
      take && (cmd.op == core_regs_pkg::OP_ADD)
      |=> (carry == $past(sum9[8])) && (half_carry == $past(half5[4]))
          && (zero == (alu_result == 8'h00)))
      else $error("add flags wrong");

   AST_SUB_CARRY: assert property (
      take && (cmd.op == core_regs_pkg::OP_SUB)
      |=> (carry == ($past(cmd.b) >= $past(cmd.a)))
          && (zero == ($past(cmd.a) == $past(cmd.b))))
      else $error("subtract flags wrong");

   AST_ROTATE: assert property (
      take && (cmd.op == core_regs_pkg::OP_RLC)
      |=> (carry == $past(cmd.a[7])) && (alu_result[0] == $past(carry)))
      else $error("rotate did not link through carry");

   COV_LONG_CALL: cover property (
      take && (cmd.op == core_regs_pkg::OP_LONG_SUBROUTINE));
   COV_CALL_RETURN: cover property (
      take && is_push ##[2:8] take && is_pop);
   COV_WINDOW_WRITE: cover property (ind_write);
   COV_SET_BEATS_CLEAR: cover property (
      wdt_timeout && take && (cmd.op == core_regs_pkg::OP_WATCHDOG_KICK));

endmodule // core_bank_pc_status_regs
`default_nettype wire

// File: bench/data_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// far side: 64-byte data memory behind the window
module data_mem_model (
   // clock
   input  wire logic       clock,
   // window
   input  wire logic [5:0] addr,
   input  wire logic       we,
   input  wire logic [7:0] wdata,
   output logic      [7:0] rdata
);
   logic [7:0] mem [64];
   // preset so an unwritten cell never reads as a lucky match
   initial foreach (mem[i]) mem[i] = ~8'(i);
   // combinational read, as the window needs
   assign rdata = mem[addr];
   // plain always: the preset above also writes mem
   always @(posedge clock) if (we) mem[addr] <= wdata;
endmodule // data_mem_model
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, cmd_valid = 0, cmd_ready, wdt = 0, iw;
   core_regs_pkg::cmd_t cmd = '0;
   logic [5:0] ip;
   logic [7:0] iwd, ird, res;
   logic [11:0] pc;
   logic [2:0] sbs, gbs;
   logic ie, to, pd, z, h, c;
   int error_cnt = 0, tests_run = 0;
   typedef struct {core_regs_pkg::op_t o; logic [7:0] a, b, r; logic c, z, h;} row_t;
   row_t rows [7] = '{'{core_regs_pkg::OP_ADD, 8'h0F, 8'h01, 8'h10, 0, 0, 1},
      '{core_regs_pkg::OP_ADD, 8'hFF, 8'h01, 8'h00, 1, 1, 1},
      '{core_regs_pkg::OP_SUB, 8'h01, 8'h03, 8'h02, 1, 0, 1},
      '{core_regs_pkg::OP_SUB, 8'h01, 8'h00, 8'hFF, 0, 0, 0},
      '{core_regs_pkg::OP_RLC, 8'h81, 8'h00, 8'h02, 1, 0, 0},
      '{core_regs_pkg::OP_RRC, 8'h02, 8'h00, 8'h81, 0, 0, 0},
      '{core_regs_pkg::OP_LOGIC, 8'h00, 8'h00, 8'h00, 0, 1, 0}};
   core_bank_pc_status_regs core_bank_pc_status_regs_i (.clock(clock),
      .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cmd_valid(cmd_valid), .cmd(cmd),
      .cmd_ready(cmd_ready), .wdt_timeout(wdt), .indirect_pointer(ip),
      .ind_write(iw), .ind_wdata(iwd), .ind_rdata(ird),
      .program_counter(pc), .special_bank_sel(sbs), .general_bank_sel(gbs),
      .alu_result(res), .irq_enable(ie), .time_out(to), .power_down(pd),
      .zero(z), .half_carry(h), .carry(c));
   data_mem_model data_mem_model_i (.clock(clock), .addr(ip), .we(iw),
      .wdata(iwd), .rdata(ird));
   // 50 MHz core clock
   always #10 clock = ~clock;
   task automatic chk(input string n, input logic [31:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, exp, got);
      end
   endtask
   // apb master, request held until pready seen high
   task automatic apb(input logic w, input logic [2:0] i, input logic [7:0] d);
      psel <= 1; penable <= 0; pwrite <= w;
      paddr <= {7'h0, i, 2'b00}; pwdata <= {24'h0, d};
      @(posedge clock);
      penable <= 1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      psel <= 0; penable <= 0;
      @(posedge clock);
   endtask
   // command held until taken; effects show one edge later, and the
   // next call offers at once so back-to-back spacing is exercised
   task automatic op(input core_regs_pkg::op_t o, input logic [11:0] t,
                     input logic [7:0] a, b);
      cmd_valid <= 1; cmd <= '{o, t, a, b};
      do @(posedge clock); while (cmd_ready !== 1'b1);
      cmd_valid <= 0;
      @(posedge clock);
   endtask
   task automatic results();
      if (error_cnt == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // hang guard, far beyond the hundred-odd cycles needed
   initial begin
      repeat (5000) @(posedge clock);
      error_cnt++;
      results();
   end
   initial begin
      repeat (20) @(posedge clock);
      resetn <= 1;
      @(posedge clock);
      chk("pc", pc, 12'h000);
      chk("to_pd", {to, pd}, 2'b11);
      foreach (rows[k]) begin
         op(rows[k].o, 12'h000, rows[k].a, rows[k].b);
         chk("alu", {res, c, z, h}, {rows[k].r, rows[k].c, rows[k].z, rows[k].h});
      end
      apb(1, 3'h1, 8'hFF);
      apb(0, 3'h1, 8'h00);
      chk("bank", rd, 32'h77);
      chk("sel", {sbs, gbs}, 6'h3F);
      apb(1, 3'h4, 8'hC5);
      chk("ptr", ip, 6'h05);
      apb(1, 3'h0, 8'h5A);
      apb(0, 3'h0, 8'h00);
      chk("window", rd, 32'h5A);
      op(core_regs_pkg::OP_LONG_BRANCH, 12'h7F0, 8'h00, 8'h00);
      chk("lbr", pc, 12'h7F0);
      op(core_regs_pkg::OP_LONG_SUBROUTINE, 12'h123, 8'h00, 8'h00);
      chk("long_subroutine", pc, 12'h123);
      op(core_regs_pkg::OP_RETURN, 12'h000, 8'h00, 8'h00);
      chk("ret", pc, 12'h7F1);
      op(core_regs_pkg::OP_PAGE_BRANCH, 12'h3FF, 8'h00, 8'h00);
      chk("pbr", pc, 12'h7FF);
      op(core_regs_pkg::OP_WRITE_PC, 12'h000, 8'h12, 8'h00);
      chk("wpc", pc, 12'h712);
      op(core_regs_pkg::OP_ADD_PC, 12'h000, 8'hF0, 8'h00);
      chk("addpc", pc, 12'h803);
      op(core_regs_pkg::OP_PAGE_CALL, 12'h155, 8'h00, 8'h00);
      chk("pcall", pc, 12'h955);
      op(core_regs_pkg::OP_RETURN_LITERAL, 12'h000, 8'h00, 8'h00);
      chk("return_literal", pc, 12'h804);
      op(core_regs_pkg::OP_TABLE_FETCH, 12'h000, 8'h00, 8'h00);
      chk("tbl", pc, 12'h805);
      op(core_regs_pkg::OP_IRQ_UNMASK, 12'h000, 8'h00, 8'h00);
      chk("ie_on", ie, 1'b1);
      op(core_regs_pkg::OP_IRQ_ENTRY, 12'h004, 8'h00, 8'h00);
      chk("irq_in", {pc, ie}, {12'h004, 1'b0});
      op(core_regs_pkg::OP_IRQ_RETURN, 12'h000, 8'h00, 8'h00);
      chk("irq_out", {pc, ie}, {12'h806, 1'b1});
      op(core_regs_pkg::OP_IRQ_MASK, 12'h000, 8'h00, 8'h00);
      chk("ie_off", ie, 1'b0);
      op(core_regs_pkg::OP_HALT, 12'h000, 8'h00, 8'h00);
      chk("halt", {to, pd}, 2'b10);
      wdt <= 1;
      @(posedge clock);
      wdt <= 0;
      @(posedge clock);
      chk("wdt", to, 1'b0);
      op(core_regs_pkg::OP_WATCHDOG_KICK, 12'h000, 8'h00, 8'h00);
      chk("kick", {to, pd}, 2'b11);
      apb(1, 3'h3, 8'hC0);
      apb(0, 3'h3, 8'h00);
      chk("st_hi", rd[7:6], 2'b00);
      chk("st", rd, 32'h18);
      apb(1, 3'h2, 8'h34);
      chk("pcl_wr", pc, 12'h834);
      apb(0, 3'h2, 8'h00);
      chk("pcl_rd", rd, 32'h34);
      apb(0, 3'h5, 8'h00);
      chk("unmapped_err", pslverr, 1'b1);
      chk("unmapped", rd, 32'h0);
      // second reset in mid-run
      resetn <= 0;
      repeat (2) @(posedge clock);
      resetn <= 1;
      @(posedge clock);
      chk("rst_pc", pc, 12'h000);
      chk("rst_st", {to, pd, ie, sbs, gbs}, 9'h180);
      results();
   end
endmodule // testbench
`default_nettype wire
